// *** logic/sadc_ctrl.sv ***
// software adc control register, channel mux selects and dac code drive
// assumes an external analog mux, 4-bit dac and comparator; cmp_in is asynchronous
//
// Functional notes
// - three analogue inputs share port 3 pins 0-2
// - bits 6:5 select the comparator input channel
// - bits 3:0 drive the 4-bit dac
// - comparator result reads back on bit 7
// - writing trigger 1 gives result before next instruction
`timescale 1ns/1ns
`default_nettype none
module sadc_ctrl
    import sadc_pkg::*;
#(
    // 3 to 9: mux update and two synchroniser stages first, result before next instruction
    parameter int SETTLE_CYC = SADC_SETTLE_CYC
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             ce,
    input  wire logic [7:0]       sfr_addr,
    input  wire logic             sfr_wr,
    input  wire logic             sfr_rd,
    input  wire logic [7:0]       sfr_wdata,
    output logic      [7:0]       sfr_rdata,
    input  wire logic             cmp_in,
    output logic      [2:0]       ain_sel,
    output logic      [3:0]       dac_code,
    output logic                  cmp_busy
);
    // ==========================================================
    // decode
    function automatic logic [2:0] ch_onehot(input logic [1:0] code);
        unique case (code)
            2'h0: ch_onehot = 3'h1;
            2'h1: ch_onehot = 3'h2;
            2'h2: ch_onehot = 3'h4;
            2'h3: ch_onehot = 3'h0;
        endcase
    endfunction

    logic       hit_wr;
    logic       hit_rd;
    logic [1:0] ch_r;
    logic [3:0] dac_r;
    logic       trig_r;
    logic       result_r;
    logic [3:0] settle_r;
    logic       cmp_meta_r;
    logic       cmp_sync_r;
    logic [2:0] ain_sel_r;
    logic [7:0] rdata_r;

    assign hit_wr = ce && sfr_wr && (sfr_addr == SADC_CTRL_ADDR);
    assign hit_rd = ce && sfr_rd && (sfr_addr == SADC_CTRL_ADDR);

    // ==========================================================
    // comparator input synchroniser
    // first stage may settle late; only the second stage is read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
        end else if (ce) begin
            cmp_meta_r <= cmp_in;
            cmp_sync_r <= cmp_meta_r;
        end
    end

    // ==========================================================
    // writable fields
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ch_r  <= SADC_CTRL_RESET[SADC_CH_HI:SADC_CH_LO];
            dac_r <= SADC_CTRL_RESET[SADC_DAC_HI:SADC_DAC_LO];
        end else if (hit_wr) begin
            ch_r  <= sfr_wdata[SADC_CH_HI:SADC_CH_LO];
            dac_r <= sfr_wdata[SADC_DAC_HI:SADC_DAC_LO];
        end
    end

    // ==========================================================
    // pin drive to mux and dac
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ain_sel_r <= 3'h0;
            dac_code  <= SADC_CTRL_RESET[SADC_DAC_HI:SADC_DAC_LO];
        end else if (ce) begin
            ain_sel_r <= ch_onehot(ch_r);
            dac_code  <= dac_r;
        end
    end
    assign ain_sel = ain_sel_r;

    // ==========================================================
    // compare trigger and settle count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trig_r   <= SADC_CTRL_RESET[SADC_TRIG_BIT];
            settle_r <= 4'h0;
        end else if (ce) begin
            if (hit_wr && sfr_wdata[SADC_TRIG_BIT]) begin
                trig_r   <= 1'b1;
                settle_r <= 4'(SETTLE_CYC);
            end else if (trig_r) begin
                if (settle_r == 4'h0) begin
                    trig_r <= 1'b0;
                end else begin
                    settle_r <= settle_r - 4'h1;
                end
            end
        end
    end
    assign cmp_busy = trig_r;

    // ==========================================================
    // result latch; reserved channel reads low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result_r <= SADC_CTRL_RESET[SADC_RESULT_BIT];
        end else if (ce && trig_r && settle_r == 4'h0) begin
            result_r <= (ch_r == 2'h3) ? 1'b0 : cmp_sync_r;
        end
    end

    // ==========================================================
    // read back
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
        end else if (ce) begin
            rdata_r <= hit_rd ? {result_r, ch_r, trig_r, dac_r} : 8'h00;
        end
    end
    assign sfr_rdata = rdata_r;

    // ==========================================================
    // checks
    sequence trig_write;
        hit_wr && sfr_wdata[SADC_TRIG_BIT];
    endsequence

    sequence trig_done;
        !trig_r;
    endsequence

    sequence latch_edge;
        ce && trig_r && settle_r == 4'h0;
    endsequence

    sequence frozen_edge;
        !ce;
    endsequence

    chk_trig_done_bound: assert property (@(posedge clk) disable iff (!resetn || !ce)
        trig_write |-> ##[1:11] trig_done)
        else $error("compare did not finish before next instruction");

    chk_trig_sets: assert property (@(posedge clk) disable iff (!resetn)
        trig_write |=> trig_r)
        else $error("trigger write did not start compare");

    chk_sel_map: assert property (@(posedge clk) disable iff (!resetn)
        ce && $past(ce) && ch_r == 2'h1 && $past(ch_r) == 2'h1 |-> ain_sel == 3'h2)
        else $error("channel 1 not mapped to second input");

    chk_sel_onehot: assert property (@(posedge clk) disable iff (!resetn)
        $countones(ain_sel) <= 1)
        else $error("more than one analogue input selected");

    chk_sel_reserved: assert property (@(posedge clk) disable iff (!resetn)
        ce && ch_r == 2'h3 |=> ain_sel == 3'h0)
        else $error("reserved channel code drove an input");

    chk_dac_follow: assert property (@(posedge clk) disable iff (!resetn)
        hit_wr ##1 ce |=> dac_code == $past(sfr_wdata[SADC_DAC_HI:SADC_DAC_LO], 2))
        else $error("dac code does not follow register");

    chk_result_read: assert property (@(posedge clk) disable iff (!resetn)
        hit_rd |=> sfr_rdata[SADC_RESULT_BIT] == $past(result_r))
        else $error("result bit not on bit 7");

    chk_result_latch: assert property (@(posedge clk) disable iff (!resetn)
        ce && trig_r && settle_r == 4'h0 && ch_r != 2'h3 |=> result_r == $past(cmp_sync_r))
        else $error("result not latched from comparator");

    chk_reserved_result: assert property (@(posedge clk) disable iff (!resetn)
        latch_edge ##0 ch_r == 2'h3 |=> !result_r)
        else $error("reserved channel latched a comparator result");

    chk_result_hold: assert property (@(posedge clk) disable iff (!resetn)
        !(ce && trig_r && settle_r == 4'h0) |=> $stable(result_r))
        else $error("result bit changed outside a latch edge");

    chk_ce_freeze: assert property (@(posedge clk) disable iff (!resetn)
        frozen_edge |=> $stable(trig_r) && $stable(settle_r) && $stable(result_r)
            && $stable(ch_r) && $stable(dac_r) && $stable(ain_sel) && $stable(dac_code)
            && $stable(sfr_rdata) && $stable(cmp_sync_r))
        else $error("state moved while clock enable was low");

    chk_read_fields: assert property (@(posedge clk) disable iff (!resetn)
        hit_rd |=> sfr_rdata[SADC_CH_HI:SADC_CH_LO] == $past(ch_r)
            && sfr_rdata[SADC_DAC_HI:SADC_DAC_LO] == $past(dac_r))
        else $error("channel or dac field not read back");

    chk_read_busy: assert property (@(posedge clk) disable iff (!resetn)
        hit_rd |=> sfr_rdata[SADC_TRIG_BIT] == $past(trig_r))
        else $error("trigger bit does not show compare in progress");

    chk_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
        ce && !hit_rd |=> sfr_rdata == 8'h00)
        else $error("read data did not return to zero");

    chk_settle_step: assert property (@(posedge clk) disable iff (!resetn)
        ce && trig_r && settle_r != 4'h0 && !(hit_wr && sfr_wdata[SADC_TRIG_BIT])
            |=> trig_r && settle_r == $past(settle_r) - 4'h1)
        else $error("settle count did not step down");

    chk_sync_stage: assert property (@(posedge clk) disable iff (!resetn)
        ce |=> cmp_sync_r == $past(cmp_meta_r))
        else $error("comparator synchroniser skipped a stage");
endmodule
`default_nettype wire

// *** logic/sadc_pkg.sv ***
// package for the software adc comparator control block
// assumes an 8-bit special function register port on the cpu clock
package sadc_pkg;
    // ==========================================================
    // register location and layout
    localparam logic [7:0] SADC_CTRL_ADDR  = 8'he8;
    localparam logic [7:0] SADC_CTRL_RESET = 8'h00;
    localparam int         SADC_RESULT_BIT = 7;
    localparam int         SADC_CH_HI      = 6;
    localparam int         SADC_CH_LO      = 5;
    localparam int         SADC_TRIG_BIT   = 4;
    localparam int         SADC_DAC_HI     = 3;
    localparam int         SADC_DAC_LO     = 0;
    localparam int         SADC_DAC_W      = 4;
    localparam int         SADC_NUM_CH     = 3;
    // ==========================================================
    // timing
    localparam int         SADC_CLK_NS     = 10;
    // comparator settle time before the result is latched
    localparam int         SADC_SETTLE_NS  = 40;
    localparam int         SADC_SETTLE_CYC = (SADC_SETTLE_NS + SADC_CLK_NS - 1) / SADC_CLK_NS;
    // shortest gap from a register write to the next instruction's read
    localparam int         SADC_NEXT_INSTR_CYC = 12;
    localparam logic [3:0] SADC_CNT_W_MAX  = 4'hf;
endpackage

// *** bench/sadc_analog.sv ***
// analog side model: three input levels compared against the dac code
// assumes levels are given in dac steps, four bits per input
`timescale 1ns/1ns
`default_nettype none
module sadc_analog (
    input  wire logic [2:0]  ain_sel,
    input  wire logic [3:0]  dac_code,
    input  wire logic [11:0] levels,
    output logic             cmp_in
);
    // ==========================================
    // comparator, low when no input is selected
    always_comb begin
        cmp_in = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (ain_sel[i]) begin
                cmp_in = levels[i*4 +: 4] >= dac_code;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/software_adc_comparator_ctrl_test.sv ***
// self-checking bench for the software adc control register
// assumes sadc_pkg, sadc_ctrl and sadc_analog are compiled first
`timescale 1ns/1ns
`default_nettype none
module software_adc_comparator_ctrl_test;
    import sadc_pkg::*;
    logic        clk, resetn, ce, sfr_wr, sfr_rd, cmp_in, cmp_busy;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rd;
    logic [2:0]  ain_sel, sel;
    logic [3:0]  dac_code, code;
    logic [11:0] levels = 12'hf09;
    int          n_errors = 0;
    int          comparisons = 0;
    sadc_ctrl dut (.clk(clk), .resetn(resetn), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cmp_in(cmp_in),
        .ain_sel(ain_sel), .dac_code(dac_code), .cmp_busy(cmp_busy));
    sadc_analog model (.ain_sel(ain_sel), .dac_code(dac_code), .levels(levels), .cmp_in(cmp_in));
    // ==========================================
    // access tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rdr(output logic [7:0] d);
        @(posedge clk);
        sfr_rd <= 1'b1;
        sfr_addr <= SADC_CTRL_ADDR;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask
    task automatic test_done();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ==========================================
    // clock, watchdog and tests
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rdr(rd);
        chk(rd, SADC_CTRL_RESET);
        $display("reset test done");
        for (int ch = 0; ch < 4; ch++) begin
            code = 4'h0;
            sel = (ch < 3) ? (3'h1 << ch) : 3'h0;
            for (int b = 3; b >= 0; b--) begin
                code[b] = 1'b1;
                wr(SADC_CTRL_ADDR, {1'b0, 2'(ch), 1'b1, code});
                repeat (SADC_NEXT_INSTR_CYC - 2) @(posedge clk);
                rdr(rd);
                chk({7'h00, cmp_busy}, 8'h00);
                chk({1'b0, ain_sel, dac_code}, {1'b0, sel, code});
                chk({1'b0, rd[6:0]}, {1'b0, 2'(ch), 1'b0, code});
                code[b] = rd[7];
            end
            chk({4'h0, code}, (ch < 3) ? {4'h0, levels[ch*4 +: 4]} : 8'h00);
            $display("channel %0d test done", ch);
        end
        wr(SADC_CTRL_ADDR, 8'h80);
        wr(8'he9, 8'hff);
        rdr(rd);
        chk(rd, 8'h00);
        $display("read-only and address test done");
        wr(SADC_CTRL_ADDR, 8'h15);
        ce <= 1'b0;
        repeat (8) @(posedge clk);
        ce <= 1'b1;
        #1 chk({cmp_busy, ain_sel, dac_code}, 8'h90);
        repeat (SADC_NEXT_INSTR_CYC) @(posedge clk);
        rdr(rd);
        chk(rd, 8'h85);
        @(posedge clk);
        #1 chk(sfr_rdata, 8'h00);
        $display("clock enable test done");
        wr(SADC_CTRL_ADDR, 8'h3f);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rdr(rd);
        chk(rd, SADC_CTRL_RESET);
        chk({cmp_busy, ain_sel, dac_code}, 8'h10);
        $display("mid-run reset test done");
        test_done();
    end
endmodule
`default_nettype wire
